// ---- core/i2c_line_sync.sv ----
`timescale 1ns/1ps

module i2c_line_sync (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Bus pins
	input wire logic sclIn,
	input wire logic sdaIn,
	// Conditioned levels and events
	output logic sclLvl,
	output logic sdaLvl,
	output logic sclRise,
	output logic sclFall,
	output logic startDet,
	output logic stopDet
);

	i2c_tgt_pkg::line_s s;
	i2c_tgt_pkg::line_s n;

	// Two stages before anything looks at a pin
	always_comb begin
		n = s;
		n.sclSy = {s.sclSy[0], sclIn};
		n.sdaSy = {s.sdaSy[0], sdaIn};
		n.sclD = s.sclSy[1];
		n.sdaD = s.sdaSy[1];
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '{sclSy: 2'h3, sdaSy: 2'h3, sclD: 1'b1, sdaD: 1'b1};
		end else begin
			s <= n;
		end
	end

	assign sclLvl = s.sclSy[1];
	assign sdaLvl = s.sdaSy[1];
	assign sclRise = s.sclSy[1] & ~s.sclD;
	assign sclFall = ~s.sclSy[1] & s.sclD;
	// SDA moving while SCL stays high frames a transfer
	assign startDet = s.sclSy[1] & s.sclD & s.sdaD & ~s.sdaSy[1];
	assign stopDet = s.sclSy[1] & s.sclD & ~s.sdaD & s.sdaSy[1];

endmodule : i2c_line_sync

// ---- core/i2c_slave_addressing_transmitter.sv ----
// Operation
// - Short address: first byte is seven address bits then direction bit.
// - Receiving party acknowledges every byte, address bytes included.
// - Long address first byte: 11110, two top address bits, direction.
// - Long address second byte holds low eight bits, then ack, data.
// - Repeated START lets master resend address with new direction.
// - Master bit rate is selected source clock over divider value.
// - Bytes per frame come from count threshold and auto stop field.
// - Master sends the target address register as address.
// - Slave raises receive request per byte, transmit request per request.
// - Slave when mode is 11, synchronous set, master select clear.
// - Slave starts as receiver, then follows received direction bit.
// - Own address matched seven-bit when width is 0, ten-bit when 1.
// - General call answered only when general call accept is set.
// - After START compare address with own address zero, set match flag.
// - Matched read makes slave transmit on master clocks, pulling SCL low only to stretch.
// - Entering slave transmit sets direction and transmit request.
// - Hold SCL low until first byte written, then ack and send.
// - Transmit request set again on each buffer to shift move.
// - After master ack send next byte or stretch until buffer filled.
// - Master NACK then STOP sets stop detect flag.
// - Master NACK then repeated START returns to address reception.
// - Bytes go most significant bit first, one SCL pulse per bit.
// - Bus busy set on START, cleared on STOP.
// - Reset hold stops traffic, releases lines, clears enables and flags.
`timescale 1ns/1ps
`include "i2c_tgt_consts.svh"

module i2c_slave_addressing_transmitter (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Bus pins, open drain
	input wire logic sclIn,
	output logic sclOut,
	output logic sclOe,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe,
	// Configuration
	input wire logic softwareResetHold,
	input wire logic [1:0] serialModeSelect,
	input wire logic synchronousSelect,
	input wire logic masterSelect,
	input wire logic ownAddressWidth,
	input wire logic generalCallAccept,
	input wire logic [9:0] ownAddressZero,
	input wire logic [9:0] targetAddressReg,
	input wire logic [15:0] bitRateDivider,
	input wire logic clockSourceSelect,
	input wire logic altSourceTick,
	input wire logic [7:0] byteCountThreshold,
	input wire logic [1:0] autoStopSelect,
	// Software strobes
	input wire logic masterStartReq,
	input wire logic txWrite,
	input wire logic [7:0] transmitBuffer,
	input wire logic rxRead,
	input wire logic startMatchClear,
	input wire logic stopDetectClear,
	input wire logic ieWrite,
	input wire logic [3:0] ieData,
	// Status
	output logic busBusyFlag,
	output logic startMatchFlag,
	output logic stopDetectFlag,
	output logic transmitRequestFlag,
	output logic receiveRequestFlag,
	output logic transferDirection,
	output logic [7:0] receiveBuffer,
	output logic [3:0] interruptEnableReg
);

	i2c_tgt_pkg::core_s s;
	i2c_tgt_pkg::core_s n;
	// Short state names, each spelled out from the package
	localparam i2c_tgt_pkg::state_e S_IDLE = i2c_tgt_pkg::S_IDLE;
	localparam i2c_tgt_pkg::state_e S_ADDR = i2c_tgt_pkg::S_ADDR;
	localparam i2c_tgt_pkg::state_e S_ADDR2 = i2c_tgt_pkg::S_ADDR2;
	localparam i2c_tgt_pkg::state_e S_ACK = i2c_tgt_pkg::S_ACK;
	localparam i2c_tgt_pkg::state_e S_TXHOLD = i2c_tgt_pkg::S_TXHOLD;
	localparam i2c_tgt_pkg::state_e S_TXREL = i2c_tgt_pkg::S_TXREL;
	localparam i2c_tgt_pkg::state_e S_TXBIT = i2c_tgt_pkg::S_TXBIT;
	localparam i2c_tgt_pkg::state_e S_TXACK = i2c_tgt_pkg::S_TXACK;
	localparam i2c_tgt_pkg::state_e S_TXSTALL = i2c_tgt_pkg::S_TXSTALL;
	localparam i2c_tgt_pkg::state_e S_RXBIT = i2c_tgt_pkg::S_RXBIT;
	localparam i2c_tgt_pkg::state_e S_WAITEND = i2c_tgt_pkg::S_WAITEND;
	localparam i2c_tgt_pkg::state_e M_START = i2c_tgt_pkg::M_START;
	localparam i2c_tgt_pkg::state_e M_BIT = i2c_tgt_pkg::M_BIT;
	localparam i2c_tgt_pkg::state_e M_HOLD = i2c_tgt_pkg::M_HOLD;
	localparam i2c_tgt_pkg::state_e M_STOP = i2c_tgt_pkg::M_STOP;
	localparam i2c_tgt_pkg::ack_next_e AFTER_RX =
		i2c_tgt_pkg::AFTER_RX;
	localparam i2c_tgt_pkg::ack_next_e AFTER_TX =
		i2c_tgt_pkg::AFTER_TX;
	localparam i2c_tgt_pkg::ack_next_e AFTER_ADDR2 =
		i2c_tgt_pkg::AFTER_ADDR2;
	logic sclLvl, sdaLvl, sclRise, sclFall, startDet, stopDet;
	logic twoWire, slaveOn, masterOn, srcTick, halfTick, countDone;
	logic [14:0] halfDiv;

	////////////////////////////////////////////////////////////////////////
	i2c_line_sync lines (
		.clk(clk),
		.rst_n(rst_n),
		.sclIn(sclIn),
		.sdaIn(sdaIn),
		.sclLvl(sclLvl),
		.sdaLvl(sdaLvl),
		.sclRise(sclRise),
		.sclFall(sclFall),
		.startDet(startDet),
		.stopDet(stopDet)
	);

	////////////////////////////////////////////////////////////////////////
	// mode decode
	assign twoWire = (serialModeSelect == `SERIAL_MODE_TWO_WIRE) &
		synchronousSelect & ~softwareResetHold;
	assign slaveOn = twoWire & ~masterSelect;
	assign masterOn = twoWire & masterSelect;

	// half-bit divider on the chosen source
	assign srcTick = (clockSourceSelect == `SOURCE_SUBSYSTEM) ?
		1'b1 : altSourceTick;
	assign halfDiv = (bitRateDivider[15:1] < `HALF_DIV_MIN) ?
		`HALF_DIV_MIN : bitRateDivider[15:1];
	assign halfTick = srcTick & (s.divCnt >= halfDiv - 15'h0001);
	assign countDone = (autoStopSelect == `AUTO_STOP_BY_COUNT) &
		(s.byteCnt == byteCountThreshold);

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		n = s;
		// Clears first so a same-cycle set still wins
		if (startMatchClear)
			n.startFlag = 1'b0;
		if (stopDetectClear)
			n.stopFlag = 1'b0;
		if (rxRead)
			n.rxReq = 1'b0;
		if (ieWrite)
			n.ie = ieData;
		if (startDet)
			n.busy = 1'b1;
		if (stopDet)
			n.busy = 1'b0;
		// Released SCL held low by someone else freezes the divider
		if (s.st inside {M_START, M_BIT, M_STOP}) begin
			if (halfTick)
				n.divCnt = 15'h0000;
			else if (srcTick & (s.sclOe | sclLvl))
				n.divCnt = s.divCnt + 15'h0001;
		end else begin
			n.divCnt = 15'h0000;
		end

		if (slaveOn) begin
			case (s.st)
			S_ADDR, S_ADDR2, S_RXBIT: begin
				// shift in MSB first on rising edges
				if (sclRise) begin
					n.shift = {s.shift[6:0], sdaLvl};
					n.bitCnt = s.bitCnt + 4'h1;
				end
				if (sclFall && s.bitCnt == `BITS_PER_BYTE) begin
					n.bitCnt = 4'h0;
					n.st = S_WAITEND;
					if (s.st == S_RXBIT) begin
						n.rxBuf = s.shift;
						n.rxReq = 1'b1;
						n.sdaOe = 1'b1;
						n.st = S_ACK;
						n.nxt = AFTER_RX;
					end else if (s.st == S_ADDR2) begin
						// low eight bits of long address
						if (s.shift == ownAddressZero[7:0]) begin
							n.tenOk = 1'b1;
							n.addressed = 1'b1;
							n.startFlag = 1'b1;
							n.sdaOe = 1'b1;
							n.st = S_ACK;
							n.nxt = AFTER_RX;
						end
					end else if (ownAddressWidth) begin
						if (s.shift[7:3] == `TEN_BIT_PREFIX &&
							s.shift[2:1] == ownAddressZero[9:8]) begin
							if (!s.shift[0]) begin
								n.sdaOe = 1'b1;
								n.st = S_ACK;
								n.nxt = AFTER_ADDR2;
							end else if (s.tenOk) begin
								n.startFlag = 1'b1;
								n.addressed = 1'b1;
								n.dir = 1'b1;
								n.txReq = 1'b1;
								n.sclOe = 1'b1;
								n.st = S_TXHOLD;
							end
						end
					end else if (s.shift[7:1] == ownAddressZero[6:0]) begin
						n.startFlag = 1'b1;
						n.addressed = 1'b1;
						n.dir = s.shift[0];
						if (s.shift[0]) begin
							n.txReq = 1'b1;
							n.sclOe = 1'b1;
							n.st = S_TXHOLD;
						end else begin
							n.sdaOe = 1'b1;
							n.st = S_ACK;
							n.nxt = AFTER_RX;
						end
					end else if (s.shift == `GENERAL_CALL_ADDR &&
						generalCallAccept) begin
						n.addressed = 1'b1;
						n.sdaOe = 1'b1;
						n.st = S_ACK;
						n.nxt = AFTER_RX;
					end
				end
			end
			S_TXHOLD: begin
				// Drive the ack before letting SCL go
				if (s.txFull && !s.sdaOe)
					n.sdaOe = 1'b1;
				else if (s.txFull) begin
					n.sclOe = 1'b0;
					n.st = S_ACK;
					n.nxt = AFTER_TX;
				end
			end
			S_ACK: begin
				if (sclFall) begin
					n.sdaOe = 1'b0;
					n.bitCnt = 4'h0;
					case (s.nxt)
					AFTER_TX: begin
						// data out on master clocks only
						n.sdaOe = ~s.txBuf[7];
						n.shift = {s.txBuf[6:0], 1'b0};
						n.txFull = 1'b0;
						n.txReq = 1'b1;
						n.bitCnt = 4'h1;
						n.st = S_TXBIT;
					end
					AFTER_ADDR2: n.st = S_ADDR2;
					default: n.st = S_RXBIT;
					endcase
				end
			end
			S_TXBIT: begin
				if (sclFall) begin
					if (s.bitCnt == `BITS_PER_BYTE) begin
						n.sdaOe = 1'b0;
						n.st = S_TXACK;
					end else begin
						n.sdaOe = ~s.shift[7];
						n.shift = {s.shift[6:0], 1'b0};
						n.bitCnt = s.bitCnt + 4'h1;
					end
				end
			end
			S_TXACK: begin
				if (sclRise)
					n.ackOk = ~sdaLvl;
				if (sclFall) begin
					if (!s.ackOk) begin
						n.st = S_WAITEND;
					end else begin
						n.sclOe = 1'b1;
						n.st = S_TXSTALL;
					end
				end
			end
			S_TXSTALL: begin
				if (s.txFull) begin
					n.sdaOe = ~s.txBuf[7];
					n.shift = {s.txBuf[6:0], 1'b0};
					n.txFull = 1'b0;
					n.txReq = 1'b1;
					n.bitCnt = 4'h1;
					n.st = S_TXREL;
				end
			end
			S_TXREL: begin
				// Data settles a cycle before SCL is freed
				n.sclOe = 1'b0;
				n.st = S_TXBIT;
			end
			default: begin
				n.sdaOe = 1'b0;
				n.sclOe = 1'b0;
			end
			endcase
			if (startDet) begin
				n.st = S_ADDR;
				n.bitCnt = 4'h0;
				n.sdaOe = 1'b0;
				n.sclOe = 1'b0;
				n.dir = 1'b0;
			end
			// stop after our transfer flags it
			if (stopDet) begin
				if (s.addressed)
					n.stopFlag = 1'b1;
				n.addressed = 1'b0;
				n.tenOk = 1'b0;
				n.st = S_IDLE;
				n.sdaOe = 1'b0;
				n.sclOe = 1'b0;
				n.dir = 1'b0;
			end
		end else if (masterOn) begin
			case (s.st)
			M_START: begin
				if (halfTick) begin
					n.sclOe = 1'b1;
					n.sdaOe = ~targetAddressReg[6];
					n.shift = {targetAddressReg[5:0], 2'h0};
					n.bitCnt = 4'h0;
					n.st = M_BIT;
				end
			end
			M_BIT: begin
				if (halfTick && s.sclOe) begin
					n.sclOe = 1'b0;
				end else if (halfTick) begin
					n.sclOe = 1'b1;
					n.bitCnt = s.bitCnt + 4'h1;
					if (s.bitCnt == `BITS_PER_BYTE) begin
						// stop on count or on NACK
						if (sdaLvl || countDone) begin
							n.sdaOe = 1'b1;
							n.st = M_STOP;
						end else begin
							n.sdaOe = 1'b0;
							n.st = M_HOLD;
						end
					end else if (s.bitCnt == 4'h7) begin
						n.sdaOe = 1'b0;
					end else begin
						n.sdaOe = ~s.shift[7];
						n.shift = {s.shift[6:0], 1'b0};
					end
				end
			end
			M_HOLD: begin
				if (s.txFull) begin
					n.sdaOe = ~s.txBuf[7];
					n.shift = {s.txBuf[6:0], 1'b0};
					n.txFull = 1'b0;
					n.txReq = 1'b1;
					n.byteCnt = s.byteCnt + 8'h01;
					n.bitCnt = 4'h0;
					n.st = M_BIT;
				end
			end
			M_STOP: begin
				if (halfTick && s.sclOe) begin
					n.sclOe = 1'b0;
				end else if (halfTick) begin
					n.sdaOe = 1'b0;
					n.stopFlag = 1'b1;
					n.dir = 1'b0;
					n.st = S_IDLE;
				end
			end
			default: begin
				n.sdaOe = 1'b0;
				n.sclOe = 1'b0;
				if (masterStartReq && !s.busy) begin
					n.sdaOe = 1'b1;
					n.dir = 1'b1;
					n.txReq = 1'b1;
					n.byteCnt = 8'h00;
					n.st = M_START;
				end
			end
			endcase
		end else begin
			n.st = S_IDLE;
			n.sdaOe = 1'b0;
			n.sclOe = 1'b0;
			n.dir = 1'b0;
			n.addressed = 1'b0;
		end

		// Buffer write after the FSM so a fresh byte is never lost
		if (txWrite) begin
			n.txBuf = transmitBuffer;
			n.txFull = 1'b1;
			n.txReq = 1'b0;
		end
		// reset hold releases lines and clears flags
		if (softwareResetHold) begin
			n.st = S_IDLE;
			n.sdaOe = 1'b0;
			n.sclOe = 1'b0;
			n.ie = 4'h0;
			n.startFlag = 1'b0;
			n.stopFlag = 1'b0;
			n.txReq = 1'b0;
			n.rxReq = 1'b0;
			n.busy = 1'b0;
			n.addressed = 1'b0;
			n.tenOk = 1'b0;
			n.txFull = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Open drain: the lines are only ever pulled low
	assign sclOut = 1'b0;
	assign sdaOut = 1'b0;
	assign sclOe = s.sclOe;
	assign sdaOe = s.sdaOe;
	assign busBusyFlag = s.busy;
	assign startMatchFlag = s.startFlag;
	assign stopDetectFlag = s.stopFlag;
	assign transmitRequestFlag = s.txReq;
	assign receiveRequestFlag = s.rxReq;
	assign transferDirection = s.dir;
	assign receiveBuffer = s.rxBuf;
	assign interruptEnableReg = s.ie;

endmodule : i2c_slave_addressing_transmitter

// ---- core/i2c_tgt_consts.svh ----
`ifndef I2C_TGT_CONSTS_SVH
`define I2C_TGT_CONSTS_SVH

// Mode and field encodings
`define SERIAL_MODE_TWO_WIRE 2'h3
`define AUTO_STOP_BY_COUNT 2'h2
`define TEN_BIT_PREFIX 5'h1e
`define GENERAL_CALL_ADDR 8'h00
`define BITS_PER_BYTE 4'h8
`define HALF_DIV_MIN 15'h0002
`define SOURCE_SUBSYSTEM 1'h0

`endif

// ---- core/i2c_tgt_pkg.sv ----
package i2c_tgt_pkg;

	typedef enum logic [3:0] {
		S_IDLE, S_ADDR, S_ADDR2, S_ACK, S_TXHOLD, S_TXREL, S_TXBIT,
		S_TXACK, S_TXSTALL, S_RXBIT, S_WAITEND,
		M_START, M_BIT, M_HOLD, M_STOP
	} state_e;

	typedef enum logic [1:0] {
		AFTER_RX, AFTER_TX, AFTER_ADDR2
	} ack_next_e;

	typedef struct packed {
		state_e st;
		ack_next_e nxt;
		logic sdaOe;
		logic sclOe;
		logic [7:0] shift;
		logic [3:0] bitCnt;
		logic addressed;
		logic tenOk;
		logic [7:0] txBuf;
		logic txFull;
		logic [7:0] rxBuf;
		logic startFlag;
		logic stopFlag;
		logic txReq;
		logic rxReq;
		logic busy;
		logic dir;
		logic [3:0] ie;
		logic [14:0] divCnt;
		logic [7:0] byteCnt;
		logic ackOk;
	} core_s;

	typedef struct packed {
		logic [1:0] sclSy;
		logic [1:0] sdaSy;
		logic sclD;
		logic sdaD;
	} line_s;

endpackage : i2c_tgt_pkg

// ---- test/i2c_bus_master_model.sv ----
`timescale 1ns/1ps

module i2c_bus_master_model (
	// Clock
	input wire logic clk,
	// Wired bus levels
	input wire logic scl,
	input wire logic sda,
	// Pull-downs, high pulls the line low
	output logic sclOe,
	output logic sdaOe
);
	initial begin
		sclOe = 1'b0;
		sdaOe = 1'b0;
	end

	////////////////////////////////////////
	task automatic half();
		repeat (10) @(posedge clk);
		#1;
	endtask : half

	// Bounded wait, so a stuck stretch cannot hang the run
	task automatic sclUp();
		int n;
		sclOe = 1'b0;
		for (n = 0; n < 900 && scl !== 1'b1; n++) @(posedge clk);
		half();
	endtask : sclUp

	task automatic start();
		sdaOe = 1'b0;
		half();
		sclUp();
		sdaOe = 1'b1;
		half();
		sclOe = 1'b1;
		half();
	endtask : start

	task automatic stop();
		sdaOe = 1'b1;
		half();
		sclUp();
		sdaOe = 1'b0;
		half();
	endtask : stop

	// acknowledge uses the same bit slot
	task automatic bitIo(input logic b, output logic r);
		sdaOe = ~b;
		half();
		sclUp();
		r = sda;
		sclOe = 1'b1;
		half();
	endtask : bitIo

	// msb first, one pulse per bit
	task automatic byteIo(input logic [7:0] d, output logic [7:0] r);
		for (int i = 7; i >= 0; i--) bitIo(d[i], r[i]);
	endtask : byteIo
endmodule : i2c_bus_master_model

// ---- test/i2c_slave_addressing_transmitter_tb.sv ----
`timescale 1ns/1ps

module i2c_slave_addressing_transmitter_tb;
	logic clk = 1'b0, rst_n = 1'b0, softwareResetHold = 1'b1;
	logic [1:0] serialModeSelect = 2'h3, autoStopSelect = 2'h2;
	logic synchronousSelect = 1'b1, masterSelect = 1'b0;
	logic ownAddressWidth = 1'b0, generalCallAccept = 1'b0;
	logic [9:0] ownAddressZero = 10'h000, targetAddressReg = 10'h05a;
	logic [15:0] bitRateDivider = 16'h0008;
	logic clockSourceSelect = 1'b0, altSourceTick = 1'b0;
	logic [7:0] byteCountThreshold = 8'h01, transmitBuffer = 8'h00;
	logic masterStartReq = 1'b0, txWrite = 1'b0, rxRead = 1'b0;
	logic startMatchClear = 1'b0, stopDetectClear = 1'b0, ieWrite = 1'b0;
	logic [3:0] ieData = 4'h0, interruptEnableReg;
	wire logic sclIn, sdaIn;
	logic sclOut, sclOe, sdaOut, sdaOe, busBusyFlag, startMatchFlag;
	logic stopDetectFlag, transmitRequestFlag, receiveRequestFlag;
	logic transferDirection, mScl, mSda;
	logic [7:0] receiveBuffer;
	logic [9:0] cap;
	int mismatches = 0, nCompared = 0;
	wire logic [7:0] st = {sclOe, sdaOe, stopDetectFlag, receiveRequestFlag,
		busBusyFlag, startMatchFlag, transferDirection, transmitRequestFlag};
	logic [6:0] cf [8] = '{7'h38, 7'h38, 7'h39, 7'h18, 7'h30, 7'h3c, 7'h3a,
		7'h38};
	logic [8:0] ad [8] = '{9'h04f, 9'h001, 9'h000, 9'h049, 9'h049, 9'h049,
		9'h049, 9'h048};

	// Open drain wiring with pull-ups
	assign sclIn = ~(sclOe | mScl);
	assign sdaIn = ~(sdaOe | mSda);
	i2c_slave_addressing_transmitter u_dut (.*);
	i2c_bus_master_model u_mst (.clk(clk), .scl(sclIn), .sda(sdaIn),
		.sclOe(mScl), .sdaOe(mSda));
	always #2.5 clk = ~clk;
	always @(posedge clk) altSourceTick <= #1 ~altSourceTick;
	always @(posedge sclIn) cap <= {cap[8:0], sdaIn};

	////////////////////////////////////////
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		nCompared++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic txw(input logic [7:0] d);
		transmitBuffer = d;
		txWrite = 1'b1;
		tick(1);
		txWrite = 1'b0;
	endtask : txw

	task automatic cfg(input logic [6:0] c, input logic [9:0] oa);
		// Enables only take a write outside hold
		softwareResetHold = 1'b0;
		ieData = 4'h5;
		ieWrite = 1'b1;
		tick(1);
		ieWrite = 1'b0;
		chk({4'h0, interruptEnableReg}, 8'h05);
		softwareResetHold = 1'b1;
		tick(1);
		chk({4'h0, interruptEnableReg}, 8'h00);
		chk(st, 8'h00);
		{clockSourceSelect, serialModeSelect, synchronousSelect, masterSelect,
			ownAddressWidth, generalCallAccept} = c;
		ownAddressZero = oa;
		tick(1);
		softwareResetHold = 1'b0;
		tick(2);
	endtask : cfg

	////////////////////////////////////////
	task automatic t_tx7();
		logic [7:0] r;
		logic b;
		cfg(7'h38, 10'h012);
		u_mst.start();
		u_mst.byteIo(8'h25, r);
		tick(2);
		chk(st, 8'h8f);
		txw(8'ha5);
		u_mst.bitIo(1'b1, b);
		chk({7'h0, b}, 8'h00);
		chk(st, 8'h0f);
		u_mst.byteIo(8'hff, r);
		chk(r, 8'ha5);
		u_mst.bitIo(1'b0, b);
		chk(st, 8'h8f);
		txw(8'h3c);
		u_mst.byteIo(8'hff, r);
		chk(r, 8'h3c);
		u_mst.bitIo(1'b1, b);
		u_mst.start();
		u_mst.byteIo(8'h24, r);
		u_mst.bitIo(1'b1, b);
		chk({5'h0, b, st[2:1]}, 8'h02);
		u_mst.byteIo(8'h5a, r);
		u_mst.bitIo(1'b1, b);
		chk({6'h0, b, st[4]}, 8'h01);
		chk(receiveBuffer, 8'h5a);
		rxRead = 1'b1;
		tick(1);
		rxRead = 1'b0;
		chk({7'h0, st[4]}, 8'h00);
		u_mst.stop();
		tick(8);
		chk({6'h0, st[5], st[3]}, 8'h02);
		$display("tx7 test finished");
	endtask : t_tx7

	task automatic t_ten();
		logic [7:0] r;
		logic b;
		cfg(7'h3a, 10'h2b4);
		u_mst.start();
		u_mst.byteIo(8'hf4, r);
		u_mst.bitIo(1'b1, b);
		chk({7'h0, b}, 8'h00);
		u_mst.byteIo(8'hb4, r);
		u_mst.bitIo(1'b1, b);
		chk({5'h0, b, st[2:1]}, 8'h02);
		u_mst.start();
		u_mst.byteIo(8'hf5, r);
		tick(2);
		chk(st, 8'h8f);
		txw(8'hc3);
		u_mst.bitIo(1'b1, b);
		u_mst.byteIo(8'hff, r);
		chk(r, 8'hc3);
		u_mst.bitIo(1'b1, b);
		u_mst.stop();
		tick(8);
		chk({6'h0, st[5], st[3]}, 8'h02);
		startMatchClear = 1'b1;
		stopDetectClear = 1'b1;
		tick(1);
		startMatchClear = 1'b0;
		stopDetectClear = 1'b0;
		chk({6'h0, st[5], st[2]}, 8'h00);
		$display("ten bit test finished");
	endtask : t_ten

	// Wrong address, general call both ways, wrong mode, width mismatch
	task automatic t_refuse();
		logic [7:0] r;
		logic b;
		for (int i = 0; i < 8; i++) begin
			cfg(cf[i], 10'h012);
			u_mst.start();
			u_mst.byteIo(ad[i][8:1], r);
			u_mst.bitIo(1'b1, b);
			chk({7'h0, b}, {7'h0, ad[i][0]});
			u_mst.stop();
			tick(8);
		end
		$display("refusal test finished");
	endtask : t_refuse

	task automatic t_master();
		int n;
		cfg(7'h7c, 10'h012);
		masterStartReq = 1'b1;
		tick(1);
		masterStartReq = 1'b0;
		for (n = 0; n < 4000 && stopDetectFlag !== 1'b1; n++) tick(1);
		chk(cap[9:2], 8'hb4);
		chk({5'h0, cap[1:0], stopDetectFlag}, 8'h05);
		$display("master test finished");
	endtask : t_master

	task automatic complete_run();
		$display("compared %0d mismatches %0d", nCompared, mismatches);
		if (mismatches == 0 && nCompared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : complete_run

	////////////////////////////////////////
	initial begin
		tick(20);
		rst_n = 1'b1;
		tick(2);
		chk(st, 8'h00);
		t_tx7();
		t_ten();
		t_refuse();
		t_master();
		complete_run();
	end

	// Whole run needs well under this span
	initial begin
		repeat (80000) @(posedge clk);
		mismatches++;
		complete_run();
	end
endmodule : i2c_slave_addressing_transmitter_tb

// ---- test/i2c_tgt_monitor.sv ----
`timescale 1ns/1ps

module i2c_tgt_monitor (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Pins
	input wire logic sclIn,
	input wire logic sclOut,
	input wire logic sclOe,
	input wire logic sdaOut,
	input wire logic sdaOe,
	// Controls
	input wire logic softwareResetHold,
	input wire logic masterSelect,
	input wire logic txWrite,
	// Status
	input wire logic busBusyFlag,
	input wire logic startMatchFlag,
	input wire logic stopDetectFlag,
	input wire logic transmitRequestFlag,
	input wire logic transferDirection,
	input wire logic [3:0] interruptEnableReg
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	////////////////////////////////////////
	property p_drv;
		sclOut == 1'b0 && sdaOut == 1'b0;
	endproperty
	a_drv: assert property (p_drv) else $error("pin driven high");
	property p_hold;
		softwareResetHold |=> !sdaOe && !sclOe && !startMatchFlag &&
			!stopDetectFlag && !transmitRequestFlag && interruptEnableReg == 4'h0;
	endproperty
	a_hold: assert property (p_hold) else $error("hold not idle");
	property p_srise;
		$rose(sclOe) && !masterSelect |-> !sclIn && transmitRequestFlag &&
			transferDirection;
	endproperty
	a_srise: assert property (p_srise) else $error("bad stretch");
	property p_shold;
		sclOe && !txWrite && !$past(txWrite) && !$past(txWrite, 2) &&
			!softwareResetHold && !masterSelect |=> sclOe;
	endproperty
	a_shold: assert property (p_shold) else $error("early release");
	property p_srel;
		sclOe && txWrite && !masterSelect |-> ##[1:3] !sclOe;
	endproperty
	a_srel: assert property (p_srel) else $error("stretch kept");
	property p_dir;
		$rose(transferDirection) && !masterSelect |-> transmitRequestFlag &&
			startMatchFlag;
	endproperty
	a_dir: assert property (p_dir) else $error("no tx request");
	property p_stop;
		$rose(stopDetectFlag) && !masterSelect |-> ##[0:4] !busBusyFlag;
	endproperty
	a_stop: assert property (p_stop) else $error("busy kept");
	property p_sda;
		$changed(sdaOe) && !$past(softwareResetHold) && !masterSelect |->
			!sclIn;
	endproperty
	a_sda: assert property (p_sda) else $error("sda moved high");
endmodule : i2c_tgt_monitor

bind i2c_slave_addressing_transmitter i2c_tgt_monitor u_mon (.*);
